// ===== core/kpm_regs.svh
/*
  Register map, field positions, codes and counts of the keyed pin
  function mapper. Assumes a 16-bit register port with byte addresses.
*/
`ifndef KPM_REGS_SVH
`define KPM_REGS_SVH

`define KPM_ADDR_W          8
`define KPM_DATA_W          16
`define KPM_OFS_KEY         8'h00
`define KPM_OFS_CTL         8'h02
`define KPM_OFS_MAP_BASE    8'h10
`define KPM_MAP_DECODE_MASK 8'hF9
`define KPM_KEY_UNLOCK      16'h2D52
`define KPM_KEY_READBACK    16'h96A5
`define KPM_CTL_LOCKED_BIT  0
`define KPM_CTL_RECFG_BIT   1
`define KPM_MAP_RESET       8'h00
`define KPM_NUM_PINS        8
`define KPM_NUM_FUNCS       15
`define KPM_CODE_NONE       8'h00
`define KPM_CODE_TIMER_HIZ  8'h10
`define KPM_CODE_ANALOG     8'hFF
`define KPM_FUNC_HAS_OUT    15'h7FF7
`define KPM_TIMEOUT_INSTR   6'h20

`endif

// ===== core/kpm_pkg.sv
/*
  Types of the keyed pin function mapper: lock states and state records.
  Assumes kpm_regs.svh on the include path.
*/
`include "kpm_regs.svh"

package kpm_pkg;

  typedef logic [7:0] kpm_code_t;
  typedef logic [`KPM_NUM_FUNCS-1:0] kpm_func_t;

  // Write access states
  typedef enum logic [1:0] {
    KPM_FRESH     = 2'b00,
    KPM_OPEN      = 2'b01,
    KPM_REOPEN    = 2'b10,
    KPM_PERMANENT = 2'b11
  } kpm_lock_e;

  // Timeout counter state
  typedef struct packed {
    logic [5:0] count;
  } kpm_timeout_s;

  // State of the mapper core, apart from the timeout count held in kpm_timeout
  typedef struct packed {
    kpm_lock_e                              lock;
    logic                                   recfg;
    logic [`KPM_NUM_PINS-1:0][7:0]          map;
    logic [`KPM_DATA_W-1:0]                 rdata;
    logic [`KPM_NUM_PINS-1:0]               pin_out;
    logic [`KPM_NUM_PINS-1:0]               pin_oe;
    logic [`KPM_NUM_PINS-1:0]               pin_ie;
    kpm_func_t                              periph_in;
    logic                                   timer_hiz;
  } kpm_core_s;

endpackage

// ===== core/kpm_timeout.sv
/*
  Instruction-count timeout of an open write session.
  Assumes one instruction-done pulse per executed instruction.
*/
`timescale 1ns/1ps
`include "kpm_regs.svh"

module kpm_timeout (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  // Control
  input  wire logic i_run,
  input  wire logic i_clear,
  input  wire logic i_step,
  // Expiry
  output logic      o_expired
);
  import kpm_pkg::*;

  kpm_timeout_s st_r;
  kpm_timeout_s st_nxt;

  // Count while open, access or lock clears
  always_comb begin
    st_nxt = st_r;
    if (!i_run || i_clear) begin
      st_nxt.count = 6'h00;
    end else if (i_step) begin
      st_nxt.count = st_r.count + 6'h01;
    end
  end

  // Last step before the limit ends the session
  assign o_expired = i_run && !i_clear && i_step && (st_r.count == (`KPM_TIMEOUT_INSTR - 6'h01));

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule // kpm_timeout

// ===== core/kpm_pin_route.sv
/*
  Routing of one mappable pin: output select, direction, buffer enables
  and the pin's share of the peripheral inputs. Purely combinational.
*/
`timescale 1ns/1ps
`include "kpm_regs.svh"

module kpm_pin_route (
  // Pin setting
  input  wire kpm_pkg::kpm_code_t i_code,
  input  wire logic               i_sel,
  input  wire logic               i_dir,
  input  wire logic               i_gpio_out,
  input  wire logic               i_pin_in,
  // Peripheral side
  input  wire kpm_pkg::kpm_func_t i_periph_out,
  input  wire kpm_pkg::kpm_func_t i_periph_dir_ctl,
  input  wire kpm_pkg::kpm_func_t i_periph_oe,
  input  wire kpm_pkg::kpm_func_t i_periph_od,
  // Results
  output logic                    o_out,
  output logic                    o_oe,
  output logic                    o_ie,
  output kpm_pkg::kpm_func_t      o_in_vec,
  output logic                    o_hiz_req
);
  import kpm_pkg::*;

  kpm_func_t hit;
  logic      drive;

  // One-hot function hit from the code
  always_comb begin
    for (int f = 0; f < `KPM_NUM_FUNCS; f++) begin
      hit[f] = (i_code == 8'(f + 1));
    end
  end

  // Pin behaviour by select, code and direction
  always_comb begin
    o_out    = 1'b0;
    o_oe     = 1'b0;
    o_ie     = 1'b1;
    o_in_vec = '0;
    drive    = |(hit & i_periph_oe);
    if (!i_sel) begin
      o_out = i_gpio_out;
      o_oe  = i_dir;
    end else if (i_code == `KPM_CODE_ANALOG) begin
      o_ie  = 1'b0;
    end else if (|(hit & i_periph_dir_ctl)) begin
      if (|(hit & i_periph_od)) begin
        o_oe     = drive && !(|(hit & i_periph_out));
        o_in_vec = hit & {`KPM_NUM_FUNCS{i_pin_in}};
      end else begin
        o_oe     = drive;
        o_out    = |(hit & i_periph_out);
        o_in_vec = drive ? '0 : (hit & {`KPM_NUM_FUNCS{i_pin_in}});
      end
    end else if (i_dir) begin
      o_oe  = 1'b1;
      o_out = |(hit & i_periph_out & `KPM_FUNC_HAS_OUT);
    end else begin
      o_in_vec = hit & {`KPM_NUM_FUNCS{i_pin_in}};
    end
  end

  // Timer hold-off request from an input pin
  assign o_hiz_req = i_sel && !i_dir && (i_code == `KPM_CODE_TIMER_HIZ) && i_pin_in;

endmodule // kpm_pin_route

// ===== core/kpm_mapper.sv
/*
  Keyed pin function mapper: key-protected register file, session lock
  with instruction timeout, per-pin function codes and pin routing.
  Assumes a plain register port with read data one cycle after the read
  strobe, an instruction-done pulse from the processor, and select and
  direction bits from the port logic. All inputs are synchronous.
*/
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "kpm_regs.svh"

module kpm_mapper (
  // Clock and reset
  input  wire logic                      i_clock,
  input  wire logic                      i_rst_n,
  // Register port
  input  wire logic [`KPM_ADDR_W-1:0]    i_addr,
  input  wire logic [`KPM_DATA_W-1:0]    i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [`KPM_DATA_W-1:0]    o_rdata,
  // Processor
  input  wire logic                      i_instr_done,
  output logic                           o_map_write_locked,
  // Port logic
  input  wire logic [`KPM_NUM_PINS-1:0]  i_pin_peripheral_select,
  input  wire logic [`KPM_NUM_PINS-1:0]  i_pin_direction,
  input  wire logic [`KPM_NUM_PINS-1:0]  i_gpio_out,
  // Pins
  input  wire logic [`KPM_NUM_PINS-1:0]  i_pin_in,
  output logic      [`KPM_NUM_PINS-1:0]  o_pin_out,
  output logic      [`KPM_NUM_PINS-1:0]  o_pin_oe,
  output logic      [`KPM_NUM_PINS-1:0]  o_pin_ie,
  // Peripheral modules
  input  wire kpm_pkg::kpm_func_t        i_periph_out,
  input  wire kpm_pkg::kpm_func_t        i_periph_dir_ctl,
  input  wire kpm_pkg::kpm_func_t        i_periph_oe,
  input  wire kpm_pkg::kpm_func_t        i_periph_od,
  output kpm_pkg::kpm_func_t             o_periph_in,
  output logic                           o_timer_outputs_hiz
);
  import kpm_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  //////////////////////////////////////////////////////////////////////////////

  kpm_core_s                st_r;
  kpm_core_s                st_nxt;

  // Address decode
  logic                     hit_key;
  logic                     hit_ctl;
  logic                     hit_map;
  logic [1:0]               map_word;
  logic                     access;

  // Session control
  logic                     is_open;
  logic                     key_good;
  logic                     expired;
  kpm_lock_e                closed_state;

  // Per-pin routing results
  logic [`KPM_NUM_PINS-1:0] rt_out;
  logic [`KPM_NUM_PINS-1:0] rt_oe;
  logic [`KPM_NUM_PINS-1:0] rt_ie;
  logic [`KPM_NUM_PINS-1:0] rt_hiz;
  kpm_func_t                rt_in_vec [`KPM_NUM_PINS];

  //////////////////////////////////////////////////////////////////////////////
  // Address decode and session status
  //////////////////////////////////////////////////////////////////////////////

  // Register selection
  assign hit_key  = (i_addr == `KPM_OFS_KEY);
  assign hit_ctl  = (i_addr == `KPM_OFS_CTL);
  assign hit_map  = ((i_addr & `KPM_MAP_DECODE_MASK) == `KPM_OFS_MAP_BASE);
  assign map_word = i_addr[2:1];

  // Any access to a mapped register
  assign access = (i_wr || i_rd) && (hit_key || hit_ctl || hit_map);

  // Session state helpers
  assign is_open  = (st_r.lock == KPM_OPEN);
  assign key_good = (i_wdata == `KPM_KEY_UNLOCK);

  // Where a closing session lands
  assign closed_state = st_r.recfg ? KPM_REOPEN : KPM_PERMANENT;

  //////////////////////////////////////////////////////////////////////////////
  // Timeout counter
  //////////////////////////////////////////////////////////////////////////////

  // Counts instruction pulses, held at zero when locked
  kpm_timeout u_timeout (
    .i_clock   (i_clock),
    .i_rst_n   (i_rst_n),
    .i_run     (is_open),
    .i_clear   (access),
    .i_step    (i_instr_done),
    .o_expired (expired)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Pin routing
  //////////////////////////////////////////////////////////////////////////////

  // One routing slice per mappable pin
  for (genvar p = 0; p < `KPM_NUM_PINS; p++) begin : g_pin
    kpm_pin_route u_route (
      .i_code           (st_r.map[p]),
      .i_sel            (i_pin_peripheral_select[p]),
      .i_dir            (i_pin_direction[p]),
      .i_gpio_out       (i_gpio_out[p]),
      .i_pin_in         (i_pin_in[p]),
      .i_periph_out     (i_periph_out),
      .i_periph_dir_ctl (i_periph_dir_ctl),
      .i_periph_oe      (i_periph_oe),
      .i_periph_od      (i_periph_od),
      .o_out            (rt_out[p]),
      .o_oe             (rt_oe[p]),
      .o_ie             (rt_ie[p]),
      .o_in_vec         (rt_in_vec[p]),
      .o_hiz_req        (rt_hiz[p])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  //////////////////////////////////////////////////////////////////////////////

  // Session, register writes, read data and routed pins
  always_comb begin
    st_nxt = st_r;

    // Session state machine
    unique case (st_r.lock)
      KPM_FRESH: begin
        if (i_wr && hit_key && key_good) begin
          st_nxt.lock = KPM_OPEN;
        end
      end
      KPM_OPEN: begin
        if (i_wr && hit_key && !key_good) begin
          st_nxt.lock = closed_state;
        end else if (expired) begin
          st_nxt.lock = closed_state;
        end
      end
      KPM_REOPEN: begin
        if (i_wr && hit_key && key_good) begin
          st_nxt.lock = KPM_OPEN;
        end
      end
      KPM_PERMANENT: begin
        st_nxt.lock = KPM_PERMANENT;
      end
    endcase

    // Writes land only while the session is open
    if (i_wr && is_open) begin
      if (hit_ctl) begin
        st_nxt.recfg = i_wdata[`KPM_CTL_RECFG_BIT];
      end
      if (hit_map) begin
        st_nxt.map[{map_word, 1'b0}] = i_wdata[7:0];
        st_nxt.map[{map_word, 1'b1}] = i_wdata[15:8];
      end
    end

    // Read data stands only in the cycle after the strobe
    st_nxt.rdata = '0;
    if (i_rd) begin
      if (hit_key) begin
        st_nxt.rdata = `KPM_KEY_READBACK;
      end else if (hit_ctl) begin
        st_nxt.rdata[`KPM_CTL_LOCKED_BIT] = !is_open;
        st_nxt.rdata[`KPM_CTL_RECFG_BIT]  = st_r.recfg;
      end else if (hit_map) begin
        st_nxt.rdata = {st_r.map[{map_word, 1'b1}], st_r.map[{map_word, 1'b0}]};
      end
    end

    // Registered pin drive
    st_nxt.pin_out   = rt_out;
    st_nxt.pin_oe    = rt_oe;
    st_nxt.pin_ie    = rt_ie;
    st_nxt.timer_hiz = |rt_hiz;

    // Module inputs gather from every pin without priority
    st_nxt.periph_in = '0;
    for (int p = 0; p < `KPM_NUM_PINS; p++) begin
      st_nxt.periph_in = st_nxt.periph_in | rt_in_vec[p];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  //////////////////////////////////////////////////////////////////////////////

  // Power-up clear starts a fresh single session
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r.lock      <= KPM_FRESH;
      st_r.recfg     <= 1'b0;
      st_r.map       <= {`KPM_NUM_PINS{`KPM_MAP_RESET}};
      st_r.rdata     <= '0;
      st_r.pin_out   <= '0;
      st_r.pin_oe    <= '0;
      st_r.pin_ie    <= '0;
      st_r.periph_in <= '0;
      st_r.timer_hiz <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  //////////////////////////////////////////////////////////////////////////////

  // Register port and status
  assign o_rdata            = st_r.rdata;
  assign o_map_write_locked = !is_open;

  // Pins and peripherals
  assign o_pin_out           = st_r.pin_out;
  assign o_pin_oe            = st_r.pin_oe;
  assign o_pin_ie            = st_r.pin_ie;
  assign o_periph_in         = st_r.periph_in;
  assign o_timer_outputs_hiz = st_r.timer_hiz;

endmodule // kpm_mapper

// ===== testbench/kpm_mapper_asserts.sv
/* Port checker of kpm_mapper: key, lock, timeout and GPIO routing.
   Assumes a bind to kpm_mapper; sees its ports only. */
`timescale 1ns/1ps
`include "kpm_regs.svh"
module kpm_mapper_asserts (
  // Clock, reset and register port
  input wire logic               i_clock,
  input wire logic               i_rst_n,
  input wire logic               i_wr,
  input wire logic               i_rd,
  input wire logic [7:0]         i_addr,
  input wire logic [15:0]        i_wdata,
  input wire logic [15:0]        o_rdata,
  // Session
  input wire logic               i_instr_done,
  input wire logic               o_map_write_locked,
  // Pins and modules
  input wire logic [7:0]         i_pin_peripheral_select,
  input wire logic [7:0]         i_pin_direction,
  input wire logic [7:0]         i_gpio_out,
  input wire logic [7:0]         o_pin_out,
  input wire logic [7:0]         o_pin_oe,
  input wire logic [7:0]         o_pin_ie,
  input wire kpm_pkg::kpm_func_t o_periph_in
);
  import kpm_pkg::*;
  typedef struct packed {logic [5:0] cnt; logic recfg; logic lk_q; logic perm;} kpm_chk_s;
  kpm_chk_s chk_r, chk_nxt;
  logic     acc, good_key, bad_key, perm_now;
  ////////////////////////////////////////////////////////////////////////
  // Access decode and permanent lock
  assign acc      = (i_wr | i_rd) & (i_addr inside {8'h00, 8'h02, 8'h10, 8'h12, 8'h14, 8'h16});
  assign good_key = i_wr & (i_addr == 8'h00) & (i_wdata == `KPM_KEY_UNLOCK);
  assign bad_key  = i_wr & (i_addr == 8'h00) & (i_wdata != `KPM_KEY_UNLOCK);
  assign perm_now = chk_r.perm | (~chk_r.lk_q & o_map_write_locked & ~chk_r.recfg);
  // Shadow timeout count, reconfigure bit, lock history
  always_comb begin
    chk_nxt      = chk_r;
    chk_nxt.cnt  = (o_map_write_locked | acc) ? 6'h00 : chk_r.cnt + {5'h00, i_instr_done};
    chk_nxt.lk_q = o_map_write_locked;
    chk_nxt.perm = perm_now;
    if (i_wr & (i_addr == 8'h02) & ~o_map_write_locked) begin
      chk_nxt.recfg = i_wdata[1];
    end
  end
  // Shadow registers
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chk_r <= 9'h002;
    end else begin
      chk_r <= chk_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  sequence s_open_bad_key;
    !o_map_write_locked ##0 bad_key;
  endsequence
  sequence s_free_good_key;
    !perm_now ##0 good_key;
  endsequence
  a_key_readback: assert property (i_rd && i_addr == 8'h00 |=> o_rdata == `KPM_KEY_READBACK)
    else $error("key readback wrong");
  a_ctl_lock_bit: assert property (i_rd && i_addr == 8'h02 |=> o_rdata[0] == $past(o_map_write_locked))
    else $error("lock status bit wrong");
  a_bad_key_locks: assert property (s_open_bad_key |=> o_map_write_locked)
    else $error("wrong key left writes open");
  a_good_key_opens: assert property (s_free_good_key |=> !o_map_write_locked)
    else $error("unlock key did not open");
  a_locked_holds: assert property (o_map_write_locked && !good_key |=> o_map_write_locked)
    else $error("writes opened without key");
  a_perm_lock_holds: assert property (perm_now |-> o_map_write_locked ##1 o_map_write_locked)
    else $error("permanent lock released");
  a_timeout_relock: assert property (chk_r.cnt == 6'h20 |-> o_map_write_locked)
    else $error("timeout did not relock");
  a_no_early_lock: assert property ($rose(o_map_write_locked) |-> chk_r.cnt == 6'h20 || $past(bad_key))
    else $error("lock without cause");
  a_gpio_route: assert property ($past(i_rst_n) |-> (((o_pin_out ^ $past(i_gpio_out)) | ~o_pin_ie
    | (o_pin_oe ^ $past(i_pin_direction))) & ~$past(i_pin_peripheral_select)) == 8'h00) else $error("gpio path wrong");
  a_unsel_zero: assert property ($past(i_rst_n) && $past(i_pin_peripheral_select) == 8'h00 |-> o_periph_in == '0)
    else $error("unselected pin fed a module");
endmodule // kpm_mapper_asserts

// ===== testbench/kpm_periph_model.sv
/* Model of the peripheral modules: random outputs and drive requests.
   Assumes the bench has seeded the random source. */
`timescale 1ns/1ps
module kpm_periph_model #(
  parameter logic [14:0] DIR_CTL    = 15'h6000,
  parameter logic [14:0] OPEN_DRAIN = 15'h4000
) (
  // Clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_rst_n,
  // Peripheral signals
  output kpm_pkg::kpm_func_t o_periph_out,
  output kpm_pkg::kpm_func_t o_periph_dir_ctl,
  output kpm_pkg::kpm_func_t o_periph_oe,
  output kpm_pkg::kpm_func_t o_periph_od
);
  import kpm_pkg::*;
  // Functions 13 and 14 steer their own pins, 14 as open drain
  assign o_periph_dir_ctl = DIR_CTL;
  assign o_periph_od      = OPEN_DRAIN;
  // New output values and drive requests each cycle
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_periph_out <= 15'h0000;
      o_periph_oe  <= 15'h0000;
    end else begin
      o_periph_out <= 15'($urandom);
      o_periph_oe  <= 15'($urandom);
    end
  end
endmodule // kpm_periph_model

// ===== testbench/kpm_mapper_test.sv
/* Testbench of kpm_mapper: key sessions, timeout, pin routing.
   Assumes the checker and peripheral model are compiled first. */
`timescale 1ns/1ps
`include "kpm_regs.svh"
module kpm_mapper_test;
  import kpm_pkg::*;
  typedef struct packed {logic [7:0] out; logic [7:0] oe; logic [7:0] ie; kpm_func_t fn; logic hiz;} kpm_exp_s;
  localparam logic [14:0] HAS_OUT = `KPM_FUNC_HAS_OUT;
  logic        clock = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, instr = 1'b0, locked, hiz;
  logic [7:0]  addr = 8'h00, sel = 8'h00, dir = 8'h00, gpio = 8'h00, pin_in = 8'h00;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [7:0]  pin_out, pin_oe, pin_ie;
  logic [7:0]  codes [8];
  kpm_func_t   pout, pdc, poe, pod, fn_in;
  kpm_exp_s    e;
  int          bad_count = 0, n_compared = 0, cycles = 0;
  ////////////////////////////////////////////////////////////////////////
  kpm_mapper u_dut (.i_clock(clock), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_instr_done(instr), .o_map_write_locked(locked), .i_pin_peripheral_select(sel),
    .i_pin_direction(dir), .i_gpio_out(gpio), .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
    .o_pin_ie(pin_ie), .i_periph_out(pout), .i_periph_dir_ctl(pdc), .i_periph_oe(poe), .i_periph_od(pod),
    .o_periph_in(fn_in), .o_timer_outputs_hiz(hiz));
  kpm_periph_model u_periph (.i_clock(clock), .i_rst_n(rst_n), .o_periph_out(pout), .o_periph_dir_ctl(pdc),
    .o_periph_oe(poe), .o_periph_od(pod));
  // Clock and hang limit
  initial begin
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    n_compared++;
    if (seen !== expv) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] x);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    check(rdata, x);
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clock);
      instr <= 1'b1;
    end
    @(posedge clock);
    instr <= 1'b0;
    #1;
  endtask
  task automatic load_map();
    for (int k = 0; k < 4; k++) begin
      wr_reg(8'h10 + 8'(2 * k), {codes[2*k+1], codes[2*k]});
    end
    rd_chk(8'h16, {codes[7], codes[6]});
  endtask
  // Pin results from select, direction, codes and peripheral state
  function automatic kpm_exp_s expect_pins();
    kpm_exp_s x;
    int       f;
    logic     feed;
    x = '0;
    for (int p = 0; p < 8; p++) begin
      f = int'(codes[p]) - 1;
      feed = 1'b0;
      x.ie[p] = !(sel[p] && codes[p] == 8'hFF);
      if (!sel[p]) begin
        x.out[p] = gpio[p];
        x.oe[p] = dir[p];
      end else if (codes[p] == 8'hFF) begin
        x.oe[p] = 1'b0;
      end else if (f >= 0 && f < 15 && pdc[f]) begin
        x.oe[p] = pod[f] ? poe[f] & ~pout[f] : poe[f];
        x.out[p] = pod[f] ? 1'b0 : pout[f];
        feed = pod[f] | ~x.oe[p];
      end else if (dir[p]) begin
        x.oe[p] = 1'b1;
        x.out[p] = (f >= 0 && f < 15) ? pout[f] & HAS_OUT[f] : 1'b0;
      end else begin
        feed = 1'b1;
        x.hiz |= pin_in[p] & (codes[p] == 8'h10);
      end
      if (feed && f >= 0 && f < 15) x.fn[f] |= pin_in[p];
    end
    return x;
  endfunction
  // Random pin traffic, all pins unselected every eighth step
  task automatic pins(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      sel <= (i % 8 == 0) ? 8'h00 : 8'($urandom);
      dir <= 8'($urandom);
      gpio <= 8'($urandom);
      pin_in <= 8'($urandom);
      #1;
      e = expect_pins();
      @(posedge clock);
      #1;
      check(16'(pin_out), 16'(e.out));
      check(16'(pin_oe), 16'(e.oe));
      check(16'(pin_ie), 16'(e.ie));
      check(16'(fn_in), 16'(e.fn));
      check(16'(hiz), 16'(e.hiz));
    end
  endtask
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'hCCBFA9E7));
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    rd_chk(8'h00, 16'h96A5);
    rd_chk(8'h02, 16'h0001);
    wr_reg(8'h10, 16'h0101);
    rd_chk(8'h10, 16'h0000);
    wr_reg(8'h00, `KPM_KEY_UNLOCK);
    rd_chk(8'h02, 16'h0000);
    wr_reg(8'h02, 16'h0002);
    wr_reg(8'h11, 16'hFFFF);
    rd_chk(8'h10, 16'h0000);
    rd_chk(8'h04, 16'h0000);
    // Mapping done with no instruction pulses in between
    codes = '{8'h01, 8'h01, 8'h04, 8'hFF, 8'h10, 8'h0F, 8'h0E, 8'h00};
    load_map();
    pins(48);
    repeat (3) begin
      foreach (codes[p]) codes[p] = ($urandom_range(17) == 17) ? 8'hFF : 8'($urandom_range(16));
      load_map();
      pins(32);
    end
    pulses(31);
    rd_chk(8'h02, 16'h0002);
    pulses(31);
    check(16'(locked), 16'h0000);
    pulses(1);
    check(16'(locked), 16'h0001);
    pulses(40);
    wr_reg(8'h00, `KPM_KEY_UNLOCK);
    check(16'(locked), 16'h0000);
    wr_reg(8'h12, 16'hFF10);
    rd_chk(8'h12, 16'hFF10);
    wr_reg(8'h02, 16'h0000);
    wr_reg(8'h00, 16'h0000);
    check(16'(locked), 16'h0001);
    wr_reg(8'h00, `KPM_KEY_UNLOCK);
    rd_chk(8'h02, 16'h0001);
    wr_reg(8'h12, 16'h0000);
    rd_chk(8'h12, 16'hFF10);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    rd_chk(8'h12, 16'h0000);
    wr_reg(8'h00, `KPM_KEY_UNLOCK);
    check(16'(locked), 16'h0000);
    complete_run();
  end
endmodule // kpm_mapper_test

bind kpm_mapper kpm_mapper_asserts u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_wr(i_wr), .i_rd(i_rd),
  .i_instr_done(i_instr_done), .o_map_write_locked(o_map_write_locked), .i_addr(i_addr),
  .i_pin_peripheral_select(i_pin_peripheral_select), .i_pin_direction(i_pin_direction), .i_gpio_out(i_gpio_out),
  .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_pin_ie(o_pin_ie), .i_wdata(i_wdata), .o_rdata(o_rdata),
  .o_periph_in(o_periph_in));
